// File: include/clk_gate_pkg.sv
// Constants for the peripheral clock gate and reset flag register block.
// Assumes a 32-bit APB slave with byte strobes, registers one word each.
`default_nettype none
package clk_gate_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_FAST_GATES = 8'h18;
    localparam logic [7:0] OFF_SLOW_GATES = 8'h1c;
    localparam logic [7:0] OFF_BACKUP_CTL = 8'h20;
    localparam logic [7:0] OFF_RST_CAUSE = 8'h24;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_FAST_GATES = 32'h0000_0000;
    localparam logic [31:0] RST_SLOW_GATES = 32'h0000_0000;
    localparam logic [31:0] RST_BACKUP_CTL = 32'h0000_0018;
    localparam logic [31:0] RST_RST_CAUSE = 32'h0c00_0000;

    // ------------------------------------------------------------
    // Implemented gate bits; all others are reserved, read as zero
    // ------------------------------------------------------------
    localparam logic [31:0] MASK_FAST_GATES = 32'h3038_fffd;
    localparam logic [31:0] MASK_SLOW_GATES = 32'h3f7e_c9ff;

    // ------------------------------------------------------------
    // Backup domain control fields
    // ------------------------------------------------------------
    localparam int BIT_SLOW_XTAL_EN = 0;
    localparam int BIT_SLOW_XTAL_STB = 1;
    localparam int BIT_SLOW_XTAL_BYP = 2;
    localparam int POS_SLOW_XTAL_DRV = 3;
    localparam int POS_RTC_SRC = 8;
    localparam int BIT_RTC_EN = 15;
    localparam int BIT_BACKUP_RST = 16;
    localparam logic [1:0] DRV_RESET = 2'h3;
    localparam logic [1:0] RTC_SRC_NONE = 2'h0;

    // ------------------------------------------------------------
    // Reset cause and internal oscillator fields
    // ------------------------------------------------------------
    localparam int BIT_INT_OSC_EN = 0;
    localparam int BIT_INT_OSC_STB = 1;
    localparam int BIT_FLAGS_CLR = 24;
    localparam int POS_FLAGS = 26;
    // Order from bit 26 up: pin, poweron, soft, free dog, window dog, lowpower
    localparam logic [5:0] FLAGS_RESET = 6'h03;
endpackage
`default_nettype wire

// File: rtl/clk_gate_regs.sv
// Peripheral clock gates, backup domain control and reset cause flags.
// Assumes a zero-wait APB master on ref_clk and separate power-on and
// backup power-on resets from the power unit.
//
// How it works
// - Timer and hires timer clocks gated by bits
// - Converter, serial and SPI clocks gated by bits
// - Port G..A and altfunc clocks gated
// - Slow gates at 0x1C, zero reset, byte access
// - DAC, power, backup, watchdog clocks gated
// - CAN, two-wire, async, SPI clocks gated
// - Slow-bus timer clocks gated from bits 8..0
// - Backup control resets 0x18 on backup reset only
// - Protected backup bits need backup write enable
// - Backup reset bit holds backup domain reset
// - RTC clock delivered only while enable set
// - Source field selects none, crystal, internal, fast/128
// - Source field locked once nonzero until reset
// - Crystal drive field, resets to highest
// - Bypass bit selects external slow clock
// - Crystal enable bit, stable flag read only
// - Cause flags on power reset, rest system reset
// - Lowpower, window and free watchdog flags set
// - Soft, poweron and pin reset flags set
// - Writing one clears all cause flags except those whose cause arrives in the same cycle
// - Internal oscillator stable flag read only
// - Internal oscillator enable bit
//
// The APB slave port was left to the implementer.
`default_nettype none
module clk_gate_regs
    import clk_gate_pkg::*;
(
    // Clock and resets
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic power_resetn,
    input wire logic backup_power_resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status and events from the rest of the chip
    input wire logic backup_write_enable,
    input wire logic slow_crystal_stable,
    input wire logic internal_slow_osc_stable,
    input wire logic lowpower_reset_evt,
    input wire logic window_dog_reset_evt,
    input wire logic free_dog_reset_evt,
    input wire logic soft_reset_evt,
    input wire logic pin_reset_evt,
    // Gated peripheral clocks
    output logic [31:0] fast_bus_gclk,
    output logic [31:0] slow_bus_gclk,
    // Oscillator and backup domain controls
    output logic slow_crystal_enable,
    output logic slow_crystal_bypass,
    output logic [1:0] slow_crystal_drive,
    output logic [1:0] rtc_source_select,
    output logic rtc_clock_gate,
    output logic backup_domain_reset,
    output logic internal_slow_osc_enable
);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic setup;
    logic wr_go;
    logic hit;
    logic [31:0] rd_val;
    logic [31:0] bmask;

    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] fast_gates_r;
    logic [31:0] slow_gates_r;
    logic slow_xtal_en_r;
    logic slow_xtal_byp_r;
    logic [1:0] slow_xtal_drv_r;
    logic [1:0] rtc_src_r;
    logic rtc_en_r;
    logic bkp_rst_r;
    logic [5:0] flags_r;
    logic flags_clr_r;
    logic int_osc_en_r;

    logic wr_fast;
    logic wr_slow;
    logic wr_bkp;
    logic wr_cause;
    logic [31:0] bkp_nxt;
    logic [31:0] cause_nxt;
    logic [31:0] bkp_cur;
    logic [31:0] cause_cur;
    logic [5:0] flag_evt;
    logic clr_flags;

    assign wr_fast = wr_go && paddr == OFF_FAST_GATES;
    assign wr_slow = wr_go && paddr == OFF_SLOW_GATES;
    assign wr_bkp = wr_go && paddr == OFF_BACKUP_CTL;
    assign wr_cause = wr_go && paddr == OFF_RST_CAUSE;

    // read view
    // Reserved bits always read zero; stable flags come live from inputs
    always_comb begin
        bkp_cur = 32'h0000_0000;
        bkp_cur[BIT_SLOW_XTAL_EN] = slow_xtal_en_r;
        bkp_cur[BIT_SLOW_XTAL_STB] = slow_crystal_stable;
        bkp_cur[BIT_SLOW_XTAL_BYP] = slow_xtal_byp_r;
        bkp_cur[POS_SLOW_XTAL_DRV +: 2] = slow_xtal_drv_r;
        bkp_cur[POS_RTC_SRC +: 2] = rtc_src_r;
        bkp_cur[BIT_RTC_EN] = rtc_en_r;
        bkp_cur[BIT_BACKUP_RST] = bkp_rst_r;
        cause_cur = 32'h0000_0000;
        cause_cur[BIT_INT_OSC_EN] = int_osc_en_r;
        cause_cur[BIT_INT_OSC_STB] = internal_slow_osc_stable;
        cause_cur[BIT_FLAGS_CLR] = flags_clr_r;
        cause_cur[POS_FLAGS +: 6] = flags_r;
    end

    // byte lanes
    // Each write merges only the lanes whose strobe is set
    assign bkp_nxt = (bkp_cur & ~bmask) | (pwdata & bmask);
    assign cause_nxt = (cause_cur & ~bmask) | (pwdata & bmask);

    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            OFF_FAST_GATES: rd_val = fast_gates_r;
            OFF_SLOW_GATES: rd_val = slow_gates_r;
            OFF_BACKUP_CTL: rd_val = bkp_cur;
            OFF_RST_CAUSE: rd_val = cause_cur;
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // APB answer, one cycle after setup
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            pready_r <= 1'b1;
            pslverr_r <= ~hit;
            prdata_r <= (hit && !pwrite) ? rd_val : 32'h0000_0000;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // Bus clock enable registers
    // ------------------------------------------------------------
    // system reset
    // Only implemented enables store; reserved bits stay zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fast_gates_r <= RST_FAST_GATES;
            slow_gates_r <= RST_SLOW_GATES;
        end else begin
            if (wr_fast) begin
                fast_gates_r <= ((fast_gates_r & ~bmask) | (pwdata & bmask))
                                & MASK_FAST_GATES;
            end
            if (wr_slow) begin
                slow_gates_r <= ((slow_gates_r & ~bmask) | (pwdata & bmask))
                                & MASK_SLOW_GATES;
            end
        end
    end

    // ------------------------------------------------------------
    // Glitch-free gating cells
    // ------------------------------------------------------------
    // Enables retime on the falling edge so, outside resetn, they only change while the
    // clock is low; a gated pulse is never split, and only resetn asserting in the high phase shortens one.
    logic [63:0] gate_en;
    logic [63:0] gate_hold_r;
    logic [63:0] gclk;

    assign gate_en = {slow_gates_r & MASK_SLOW_GATES,
                      fast_gates_r & MASK_FAST_GATES};

    genvar gi;
    generate
        for (gi = 0; gi < 64; gi = gi + 1) begin : g_gate
            always_ff @(negedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    gate_hold_r[gi] <= 1'b0;
                end else begin
                    gate_hold_r[gi] <= gate_en[gi];
                end
            end
            assign gclk[gi] = ref_clk & gate_hold_r[gi];
        end
    endgenerate

    assign fast_bus_gclk = gclk[31:0];
    assign slow_bus_gclk = gclk[63:32];

    // ------------------------------------------------------------
    // Backup domain control
    // ------------------------------------------------------------
    // Lives on the backup power-on reset, so system resets leave it alone.
    always_ff @(posedge ref_clk or negedge backup_power_resetn) begin
        if (!backup_power_resetn) begin
            bkp_rst_r <= RST_BACKUP_CTL[BIT_BACKUP_RST];
        end else if (wr_bkp) begin
            bkp_rst_r <= bkp_nxt[BIT_BACKUP_RST];
        end
    end

    // backup-only reset
    // The software reset bit holds every other field at its reset value
    always_ff @(posedge ref_clk or negedge backup_power_resetn) begin
        if (!backup_power_resetn) begin
            slow_xtal_en_r <= RST_BACKUP_CTL[BIT_SLOW_XTAL_EN];
            slow_xtal_byp_r <= RST_BACKUP_CTL[BIT_SLOW_XTAL_BYP];
            slow_xtal_drv_r <= RST_BACKUP_CTL[POS_SLOW_XTAL_DRV +: 2];
            rtc_src_r <= RST_BACKUP_CTL[POS_RTC_SRC +: 2];
            rtc_en_r <= RST_BACKUP_CTL[BIT_RTC_EN];
        end else if (bkp_rst_r) begin
            slow_xtal_en_r <= RST_BACKUP_CTL[BIT_SLOW_XTAL_EN];
            slow_xtal_byp_r <= RST_BACKUP_CTL[BIT_SLOW_XTAL_BYP];
            slow_xtal_drv_r <= RST_BACKUP_CTL[POS_SLOW_XTAL_DRV +: 2];
            rtc_src_r <= RST_BACKUP_CTL[POS_RTC_SRC +: 2];
            rtc_en_r <= RST_BACKUP_CTL[BIT_RTC_EN];
        end else if (wr_bkp) begin
            slow_xtal_drv_r <= bkp_nxt[POS_SLOW_XTAL_DRV +: 2];
            if (backup_write_enable) begin
                slow_xtal_en_r <= bkp_nxt[BIT_SLOW_XTAL_EN];
                slow_xtal_byp_r <= bkp_nxt[BIT_SLOW_XTAL_BYP];
                rtc_en_r <= bkp_nxt[BIT_RTC_EN];
                if (rtc_src_r == RTC_SRC_NONE) begin
                    rtc_src_r <= bkp_nxt[POS_RTC_SRC +: 2];
                end
            end
        end
    end

    assign slow_crystal_enable = slow_xtal_en_r;
    assign slow_crystal_bypass = slow_xtal_byp_r;
    assign slow_crystal_drive = slow_xtal_drv_r;
    // source code to the clock mux
    assign rtc_source_select = rtc_src_r;
    assign rtc_clock_gate = rtc_en_r;
    assign backup_domain_reset = bkp_rst_r;

    // ------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------
    // hardware cause events
    assign flag_evt = {lowpower_reset_evt, window_dog_reset_evt,
                       free_dog_reset_evt, soft_reset_evt,
                       1'b0, pin_reset_evt};
    assign clr_flags = wr_cause && cause_nxt[BIT_FLAGS_CLR];

    // flags survive system resets
    // A cause arriving with the clear still sets its flag.
    always_ff @(posedge ref_clk or negedge power_resetn) begin
        if (!power_resetn) begin
            flags_r <= FLAGS_RESET;
        end else if (clr_flags) begin
            flags_r <= flag_evt;
        end else begin
            flags_r <= flags_r | flag_evt;
        end
    end

    // read-only bits are not stored from writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flags_clr_r <= RST_RST_CAUSE[BIT_FLAGS_CLR];
            int_osc_en_r <= RST_RST_CAUSE[BIT_INT_OSC_EN];
        end else if (wr_cause) begin
            flags_clr_r <= cause_nxt[BIT_FLAGS_CLR];
            int_osc_en_r <= cause_nxt[BIT_INT_OSC_EN];
        end
    end

    assign internal_slow_osc_enable = int_osc_en_r;

endmodule
`default_nettype wire

// File: dv/osc_model.sv
// Oscillator stand-in: each stable flag rises after a settle count.
// Assumes the enables come straight from the block under test.
`default_nettype none
module osc_model #(
    parameter int XTAL_SETTLE = 12,
    parameter int IRC_SETTLE = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Enables and flags
    input wire logic slow_crystal_enable,
    input wire logic internal_slow_osc_enable,
    output logic slow_crystal_stable,
    output logic internal_slow_osc_stable
);
    timeunit 1ns;
    timeprecision 1ps;
    int xcnt_r;
    int icnt_r;
    // A stopped oscillator loses its flag at once, not after a delay
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xcnt_r <= 0;
            icnt_r <= 0;
        end else begin
            xcnt_r <= slow_crystal_enable ? xcnt_r + 1 : 0;
            icnt_r <= internal_slow_osc_enable ? icnt_r + 1 : 0;
        end
    end
    assign slow_crystal_stable = slow_crystal_enable &&
        xcnt_r >= XTAL_SETTLE;
    assign internal_slow_osc_stable = internal_slow_osc_enable &&
        icnt_r >= IRC_SETTLE;
endmodule
`default_nettype wire

// File: dv/clk_gate_chk.sv
// Port checks for the clock gate and reset flag register block.
// Assumes zero-wait APB answers and glitch-free AND gates.
`default_nettype none
module clk_gate_chk
    import clk_gate_pkg::*;
(
    // Clock and resets
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic backup_power_resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Gates and backup controls
    input wire logic backup_write_enable,
    input wire logic [31:0] fast_bus_gclk,
    input wire logic [31:0] slow_bus_gclk,
    input wire logic slow_crystal_enable,
    input wire logic slow_crystal_bypass,
    input wire logic [1:0] slow_crystal_drive,
    input wire logic [1:0] rtc_source_select,
    input wire logic rtc_clock_gate,
    input wire logic backup_domain_reset
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    logic mapped;
    assign mapped = paddr inside {OFF_FAST_GATES, OFF_SLOW_GATES,
        OFF_BACKUP_CTL, OFF_RST_CAUSE};
    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready not a single cycle after setup");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err)
        else $error("pslverr without pready");
    property p_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("read data outside an answer");
    property p_unmapped;
        psel && !penable && !mapped |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_fast_rsvd;
        @(negedge ref_clk) (fast_bus_gclk & ~MASK_FAST_GATES) == 32'h0;
    endproperty
    a_fast_rsvd: assert property (p_fast_rsvd)
        else $error("reserved fast clock toggles");
    property p_slow_rsvd;
        @(negedge ref_clk) (slow_bus_gclk & ~MASK_SLOW_GATES) == 32'h0;
    endproperty
    a_slow_rsvd: assert property (p_slow_rsvd)
        else $error("reserved slow clock toggles");
    property p_gclk_low;
        fast_bus_gclk == 32'h0 && slow_bus_gclk == 32'h0;
    endproperty
    a_gclk_low: assert property (p_gclk_low)
        else $error("gated clock high in low phase");
    property p_src_lock;
        disable iff (!backup_power_resetn)
        rtc_source_select != 2'h0 |=>
            backup_domain_reset || $stable(rtc_source_select);
    endproperty
    a_src_lock: assert property (p_src_lock)
        else $error("locked clock source changed");
    property p_backup_domain_reset_hold;
        disable iff (!backup_power_resetn)
        backup_domain_reset && $past(backup_domain_reset) |->
            rtc_source_select == 2'h0 && !rtc_clock_gate &&
            slow_crystal_drive == 2'h3 && !slow_crystal_enable;
    endproperty
    a_backup_domain_reset_hold: assert property (p_backup_domain_reset_hold)
        else $error("backup fields not held in reset");
    property p_protect;
        disable iff (!backup_power_resetn)
        !backup_write_enable ##1 !backup_write_enable |->
            backup_domain_reset || $stable({slow_crystal_enable,
            slow_crystal_bypass, rtc_clock_gate});
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected backup bit changed");
    c_unmapped: cover property (pslverr);
    c_src: cover property (rtc_source_select == 2'h3);
    c_backup_domain_reset: cover property (backup_domain_reset);
endmodule
bind clk_gate_regs clk_gate_chk u_chk (.ref_clk, .resetn,
    .backup_power_resetn, .psel, .penable, .paddr, .prdata, .pready,
    .pslverr, .backup_write_enable, .fast_bus_gclk, .slow_bus_gclk,
    .slow_crystal_enable, .slow_crystal_bypass, .slow_crystal_drive,
    .rtc_source_select, .rtc_clock_gate, .backup_domain_reset);
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the clock gate and reset flag registers.
// Assumes the oscillator stand-in and the bound checker compile first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_gate_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic power_resetn = 1'b0;
    logic backup_power_resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic backup_write_enable = 1'b0;
    logic [4:0] evt = 5'h0;
    logic [31:0] prdata, fast_bus_gclk, slow_bus_gclk;
    logic pready, pslverr, slow_crystal_stable, internal_slow_osc_stable;
    logic slow_crystal_enable, slow_crystal_bypass, rtc_clock_gate;
    logic backup_domain_reset, internal_slow_osc_enable;
    logic [1:0] slow_crystal_drive, rtc_source_select;
    int flag_pos[5] = '{26, 28, 29, 30, 31};
    int err_total = 0;
    int checked = 0;
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    clk_gate_regs u_dut (
        .ref_clk, .resetn, .power_resetn, .backup_power_resetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .backup_write_enable,
        .slow_crystal_stable, .internal_slow_osc_stable,
        .lowpower_reset_evt(evt[4]), .window_dog_reset_evt(evt[3]),
        .free_dog_reset_evt(evt[2]), .soft_reset_evt(evt[1]),
        .pin_reset_evt(evt[0]), .fast_bus_gclk, .slow_bus_gclk,
        .slow_crystal_enable, .slow_crystal_bypass, .slow_crystal_drive,
        .rtc_source_select, .rtc_clock_gate, .backup_domain_reset,
        .internal_slow_osc_enable
    );
    osc_model u_osc (.ref_clk, .rst_n(power_resetn), .slow_crystal_enable,
        .internal_slow_osc_enable, .slow_crystal_stable,
        .internal_slow_osc_stable);
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic test_done;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] rd, output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        // Read right after the edge: these are the values the master samples
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            test_done();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hf);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, s, r, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, 4'h0, r, e);
        chk(r, exp);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rdc(OFF_FAST_GATES, RST_FAST_GATES);
        rdc(OFF_SLOW_GATES, RST_SLOW_GATES);
        rdc(OFF_BACKUP_CTL, RST_BACKUP_CTL);
        rdc(OFF_RST_CAUSE, RST_RST_CAUSE);
        apb(8'h28, 1'b0, 32'h0, 4'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        $display("test reset values done");
    endtask
    task automatic t_gates;
        wr(OFF_FAST_GATES, MASK_FAST_GATES);
        wr(OFF_SLOW_GATES, MASK_SLOW_GATES);
        rdc(OFF_FAST_GATES, MASK_FAST_GATES);
        rdc(OFF_SLOW_GATES, MASK_SLOW_GATES);
        @(posedge ref_clk);
        #3;
        chk(fast_bus_gclk, MASK_FAST_GATES);
        chk(slow_bus_gclk, MASK_SLOW_GATES);
        #4;
        chk(fast_bus_gclk | slow_bus_gclk, 32'h0);
        wr(OFF_SLOW_GATES, 32'h0, 4'b0010);
        wr(OFF_FAST_GATES, 32'h0, 4'b1100);
        rdc(OFF_SLOW_GATES, MASK_SLOW_GATES & 32'hffff_00ff);
        rdc(OFF_FAST_GATES, MASK_FAST_GATES & 32'h0000_ffff);
        @(posedge ref_clk);
        #3;
        chk(slow_bus_gclk, MASK_SLOW_GATES & 32'hffff_00ff);
        chk(fast_bus_gclk, MASK_FAST_GATES & 32'h0000_ffff);
        $display("test gates done");
    endtask
    task automatic t_backup;
        wr(OFF_BACKUP_CTL, 32'h0000_8315);
        rdc(OFF_BACKUP_CTL, 32'h0000_0010);
        backup_write_enable <= 1'b1;
        wr(OFF_BACKUP_CTL, 32'h0000_8115);
        #1;
        chk({rtc_clock_gate, rtc_source_select, slow_crystal_bypass,
            slow_crystal_enable, slow_crystal_drive}, 7'h5e);
        repeat (16) @(posedge ref_clk);
        rdc(OFF_BACKUP_CTL, 32'h0000_8117);
        wr(OFF_BACKUP_CTL, 32'h0000_8215);
        #1;
        chk(rtc_source_select, 2'h1);
        for (int s = 0; s < 4; s++) begin
            wr(OFF_BACKUP_CTL, 32'h0001_0000);
            // Held fields return to reset one edge after the bit lands
            @(posedge ref_clk);
            #1;
            chk({backup_domain_reset, rtc_source_select,
                slow_crystal_drive}, 5'h13);
            wr(OFF_BACKUP_CTL, 32'h0);
            wr(OFF_BACKUP_CTL, (32'(s) << 8) | (32'(s) << 3));
            #1;
            chk({rtc_source_select, slow_crystal_drive},
                {s[1:0], s[1:0]});
        end
        $display("test backup domain done");
    endtask
    task automatic t_flags;
        logic [31:0] exp;
        exp = RST_RST_CAUSE | 32'h3;
        wr(OFF_RST_CAUSE, 32'h0000_0001);
        #1;
        chk({31'h0, internal_slow_osc_enable}, 32'h1);
        repeat (8) @(posedge ref_clk);
        rdc(OFF_RST_CAUSE, exp);
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            evt[i] <= 1'b1;
            @(posedge ref_clk);
            evt[i] <= 1'b0;
            exp[flag_pos[i]] = 1'b1;
            rdc(OFF_RST_CAUSE, exp);
        end
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rdc(OFF_RST_CAUSE, 32'hfc00_0000);
        rdc(OFF_BACKUP_CTL, 32'h0000_0318);
        rdc(OFF_SLOW_GATES, RST_SLOW_GATES);
        wr(OFF_RST_CAUSE, 32'h0100_0000);
        rdc(OFF_RST_CAUSE, 32'h0100_0000);
        wr(OFF_RST_CAUSE, 32'hfc00_0000);
        rdc(OFF_RST_CAUSE, 32'h0000_0000);
        $display("test reset flags done");
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        power_resetn <= 1'b1;
        backup_power_resetn <= 1'b1;
        t_reset();
        t_gates();
        t_backup();
        t_flags();
        test_done();
    end
endmodule
`default_nettype wire
